/* rtl/pwm_fault_delay_dither_ctrl.sv */
`timescale 1ns/10ps
// Summary of operation
// - Code 0 ignores triggers; code 1 stops output, jumps opposite, waits.
// - Code 2 runs opposite cycle then waits; code 3 runs it while faulted.
// - Code 4 stops all, keeps period; code 5 stops all with deadband.
// - Code 6 stops all, jumps next cycle, waits; code 7 awaits software.
// - Codes 8,9 stop on edge; code 10 stops while level active.
// - While faulted, each enabled output is forced to its fault level.
// - Delay prescaler divides delay clock by 1, 2, 4 or 8.
// - Delay start source: A set, A clear, B set, or cycle end.
// - Delay function: off, input blanking, output event; code 3 reserved.
// - Eight-bit delay length counted in prescaled timer cycles.
// - Fraction phase select adds dithering to ramp A and deadtime; ramp B always gets it.
// - Step added to 4-bit accumulator each cycle end; overflow adjusts.
// - Step value is double-buffered and loaded at update condition.
// - With halt_raises_fault set, a debug halt faults and sets triggers.
// - Without run_during_break, timer halts and ignores events at break.
module pwm_fault_delay_dither_ctrl (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        trigger_a,
    input  wire logic        trigger_b,
    input  wire logic        debug_break,
    input  wire logic        compare_a_set_match,
    input  wire logic        compare_a_clear_match,
    input  wire logic        compare_b_set_match,
    input  wire logic        compare_b_clear_match,
    input  wire logic        update_condition,
    input  wire logic [3:0]  waveform_in,
    output logic [3:0]       waveform_output_pin,
    output logic             output_event,
    output logic             input_blanking,
    output logic             fraction_adjust_a,
    output logic             fraction_adjust_b,
    output logic             deadtime_adjust,
    output logic             timer_halted,
    output logic             stop_a,
    output logic             stop_b,
    output logic             irq
);
    logic [7:0] fault_output_override_reg;
    logic [7:0] delay_control_reg;
    logic [7:0] delay_length_reg;
    logic [7:0] fraction_phase_select_reg;
    logic [3:0] fraction_step_value_reg;
    logic [3:0] step_active_reg;
    logic [7:0] halt_behaviour_control_reg;
    logic [3:0] trigger_reaction_select_reg;
    logic [3:0] unlock_reg;
    logic [2:0] int_status_reg;
    logic [2:0] int_enable_reg;
    logic [3:0] acc_reg;
    logic [2:0] div_reg;
    logic [7:0] dly_cnt_reg;
    logic       dly_run_reg;
    logic [1:0] trig_sync1_reg;
    logic [1:0] trig_sync2_reg;
    logic [1:0] trig_prev_reg;
    logic       brk_sync1_reg;
    logic       brk_sync2_reg;
    logic       pending_aw_reg;
    logic       pending_w_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic       wstrb0_reg;
    pwm_fault_pkg::react_state_t state_reg;
    pwm_fault_pkg::react_state_t state_next;
    // Address decode and write handshake.
    wire        aw_take   = s_axi_awvalid & s_axi_awready;
    wire        w_take    = s_axi_wvalid & s_axi_wready;
    wire        have_aw   = pending_aw_reg | aw_take;
    wire        have_w    = pending_w_reg | w_take;
    wire        wr_fire   = have_aw & have_w & ~s_axi_bvalid;
    wire [7:0]  wr_addr   = pending_aw_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data   = pending_w_reg ? wdata_reg : s_axi_wdata;
    wire        wr_lane   = pending_w_reg ? wstrb0_reg : s_axi_wstrb[0];
    wire        wr_ok     = wr_fire & wr_lane;
    wire [7:0]  wd        = wr_data[7:0];
    wire [5:0]  wr_idx    = wr_addr[7:2];
    wire [5:0]  rd_idx    = s_axi_araddr[7:2];
    wire        wr_ovr    = wr_ok & (wr_idx == pwm_fault_pkg::IDX_FAULT_OVR[5:0]);
    wire        unlocked  = unlock_reg != 4'h0;
    wire        wr_unlock = wr_ok & (wr_idx == pwm_fault_pkg::IDX_UNLOCK[5:0]);
    wire        wr_clear  = wr_ok & (wr_idx == pwm_fault_pkg::IDX_INT_CLEAR[5:0]);
    wire        wr_state  = wr_ok & (wr_idx == pwm_fault_pkg::IDX_STATE[5:0]);
    // Synchronised inputs and edges.
    wire        run_brk   =
        halt_behaviour_control_reg[pwm_fault_pkg::RUN_BREAK_BIT];
    wire        halt_flt  =
        halt_behaviour_control_reg[pwm_fault_pkg::HALT_FAULT_BIT];
    wire        halted    = brk_sync2_reg & ~run_brk;
    wire [1:0]  trig_lvl  = trig_sync2_reg & {2{~input_blanking}};
    wire [1:0]  trig_live = halted ? 2'b00 : trig_lvl;
    wire [1:0]  trig_edge = trig_live & ~trig_prev_reg;
    wire        halt_evt  = halted & halt_flt;
    wire        fault_lvl = (|trig_live) | halt_evt;
    wire        fault_edg = (|trig_edge) | halt_evt;
    wire [3:0]  mode      = trigger_reaction_select_reg;
    wire [1:0]  dsrc      = delay_control_reg[pwm_fault_pkg::DLY_SRC_LSB +: 2];
    wire        dly_start =
        (dsrc == pwm_fault_pkg::SRC_A_SET) ? compare_a_set_match :
        (dsrc == pwm_fault_pkg::SRC_A_CLR) ? compare_a_clear_match :
        (dsrc == pwm_fault_pkg::SRC_B_SET) ? compare_b_set_match :
                                             compare_b_clear_match;
    wire [1:0]  ddiv      = delay_control_reg[pwm_fault_pkg::DLY_DIV_LSB +: 2];
    wire        dly_tick  =
        (ddiv == 2'h0) ? 1'b1 :
        (ddiv == 2'h1) ? (div_reg[0] == 1'b1) :
        (ddiv == 2'h2) ? (div_reg[1:0] == 2'h3) :
                         (div_reg == 3'h7);
    wire [1:0]  dfunc     = delay_control_reg[1:0];
    wire        dly_done  = dly_run_reg & dly_tick &
                            (dly_cnt_reg + 8'h01 >= delay_length_reg);
    wire        cycle_end = compare_b_clear_match & ~halted;
    wire [4:0]  acc_sum   = {1'b0, acc_reg} + {1'b0, step_active_reg};
    wire        acc_ovf   = cycle_end & acc_sum[4];
    wire [1:0]  fsel      = fraction_phase_select_reg[1:0];
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pwm_fault_pkg::ST_RUN: begin
                if (fault_edg && mode != pwm_fault_pkg::RX_NONE) begin
                    case (mode)
                        pwm_fault_pkg::RX_JUMP_OPP,
                        pwm_fault_pkg::RX_ALL_NEXT:
                            state_next = pwm_fault_pkg::ST_WAIT;
                        pwm_fault_pkg::RX_RUN_OPP:
                            state_next = pwm_fault_pkg::ST_OPP;
                        pwm_fault_pkg::RX_ALL_SW:
                            state_next = pwm_fault_pkg::ST_SW;
                        default:
                            state_next = pwm_fault_pkg::ST_FAULTED;
                    endcase
                end
            end
            pwm_fault_pkg::ST_OPP:
                if (cycle_end) state_next = pwm_fault_pkg::ST_WAIT;
            pwm_fault_pkg::ST_WAIT:
                if (!fault_lvl && cycle_end) state_next = pwm_fault_pkg::ST_RUN;
            pwm_fault_pkg::ST_FAULTED: begin
                if (mode == pwm_fault_pkg::RX_EDGE_NEXT ||
                    mode == pwm_fault_pkg::RX_EDGE_KEEP) begin
                    if (cycle_end) state_next = pwm_fault_pkg::ST_RUN;
                end else if (!fault_lvl) begin
                    state_next = pwm_fault_pkg::ST_RUN;
                end
            end
            pwm_fault_pkg::ST_SW:
                if (wr_state) state_next = pwm_fault_pkg::ST_RUN;
            default: state_next = pwm_fault_pkg::ST_RUN;
        endcase
    end
    wire stopping  = state_next != pwm_fault_pkg::ST_RUN;
    wire all_modes = mode >= pwm_fault_pkg::RX_ALL_KEEP &&
                     mode <= pwm_fault_pkg::RX_ALL_SW;
    wire [1:0] stop_next = !stopping ? 2'b00 :
                           all_modes ? 2'b11 :
                           {trig_live[1] | trig_prev_reg[1] | stop_b,
                            trig_live[0] | trig_prev_reg[0] | stop_a};
    wire [3:0] ovr_en  = fault_output_override_reg[pwm_fault_pkg::OVR_EN_LSB +: 4];
    wire [3:0] wave_next = stopping ?
        ((ovr_en & fault_output_override_reg[3:0]) | (~ovr_en & 4'h0)) :
        waveform_in;
    wire [2:0] int_set = {acc_ovf, trig_edge[1] | halt_evt,
                          trig_edge[0] | halt_evt};

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= pwm_fault_pkg::ST_RUN;
            waveform_output_pin <= 4'h0;
            stop_a <= 1'b0;
            stop_b <= 1'b0;
            timer_halted <= 1'b0;
            trig_sync1_reg <= 2'b00;
            trig_sync2_reg <= 2'b00;
            trig_prev_reg <= 2'b00;
            brk_sync1_reg <= 1'b0;
            brk_sync2_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            waveform_output_pin <= wave_next;
            stop_a <= stop_next[0];
            stop_b <= stop_next[1];
            timer_halted <= halted;
            trig_sync1_reg <= {trigger_b, trigger_a};
            trig_sync2_reg <= trig_sync1_reg;
            trig_prev_reg <= trig_live;
            brk_sync1_reg <= debug_break;
            brk_sync2_reg <= brk_sync1_reg;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            div_reg <= 3'h0;
            dly_cnt_reg <= 8'h00;
            dly_run_reg <= 1'b0;
            output_event <= 1'b0;
            input_blanking <= 1'b0;
        end else begin
            div_reg <= div_reg + 3'h1;
            output_event <= dly_done && dfunc == pwm_fault_pkg::DLY_EVENT;
            if (dly_start && !halted && (dfunc == pwm_fault_pkg::DLY_BLANK ||
                                         dfunc == pwm_fault_pkg::DLY_EVENT)) begin
                dly_run_reg <= 1'b1;
                dly_cnt_reg <= 8'h00;
                input_blanking <= dfunc == pwm_fault_pkg::DLY_BLANK;
            end else if (dly_done) begin
                dly_run_reg <= 1'b0;
                input_blanking <= 1'b0;
            end else if (dly_run_reg && dly_tick) begin
                dly_cnt_reg <= dly_cnt_reg + 8'h01;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            acc_reg <= 4'h0;
            step_active_reg <= 4'h0;
            fraction_adjust_a <= 1'b0;
            fraction_adjust_b <= 1'b0;
            deadtime_adjust <= 1'b0;
        end else begin
            if (update_condition) step_active_reg <= fraction_step_value_reg;
            if (cycle_end) acc_reg <= acc_sum[3:0];
            fraction_adjust_b <= acc_ovf;
            fraction_adjust_a <= acc_ovf & fsel[0];
            deadtime_adjust <= acc_ovf & fsel[1];
        end
    end
    // Register writes; unlock gate on the override register.
    always_ff @(posedge clock) begin
        if (rst) begin
            fault_output_override_reg <= pwm_fault_pkg::REG_RESET;
            delay_control_reg <= pwm_fault_pkg::REG_RESET;
            delay_length_reg <= pwm_fault_pkg::REG_RESET;
            fraction_phase_select_reg <= pwm_fault_pkg::REG_RESET;
            fraction_step_value_reg <= 4'h0;
            halt_behaviour_control_reg <= pwm_fault_pkg::REG_RESET;
            trigger_reaction_select_reg <= 4'h0;
            unlock_reg <= 4'h0;
            int_enable_reg <= 3'h0;
        end else begin
            if (wr_unlock && wd == pwm_fault_pkg::UNLOCK_KEY)
                unlock_reg <= pwm_fault_pkg::UNLOCK_WINDOW;
            else if (unlocked)
                unlock_reg <= unlock_reg - 4'h1;
            if (wr_ovr && unlocked) fault_output_override_reg <= wd;
            if (wr_ok) begin
                case (wr_idx)
                    pwm_fault_pkg::IDX_DLY_CTRL[5:0]:
                        delay_control_reg <= {2'b00, wd[5:0]};
                    pwm_fault_pkg::IDX_DLY_LEN[5:0]: delay_length_reg <= wd;
                    pwm_fault_pkg::IDX_FRAC_SEL[5:0]:
                        fraction_phase_select_reg <= {6'h00, wd[1:0]};
                    pwm_fault_pkg::IDX_FRAC_STEP[5:0]:
                        fraction_step_value_reg <= wd[3:0];
                    pwm_fault_pkg::IDX_HALT_CTRL[5:0]:
                        halt_behaviour_control_reg <= {5'h00, wd[2], 1'b0, wd[0]};
                    pwm_fault_pkg::IDX_TRIG_MODE[5:0]:
                        trigger_reaction_select_reg <= wd[3:0];
                    pwm_fault_pkg::IDX_INT_ENABLE[5:0]:
                        int_enable_reg <= wd[2:0];
                    default: ;
                endcase
            end
        end
    end
    // Sticky status: a set in the same cycle as a clear wins.
    always_ff @(posedge clock) begin
        if (rst) begin
            int_status_reg <= 3'h0;
            irq <= 1'b0;
        end else begin
            int_status_reg <= (int_status_reg & ~(wr_clear ? wd[2:0] : 3'h0))
                              | int_set;
            irq <= |(int_status_reg & int_enable_reg);
        end
    end
    wire [7:0] rd_val =
        (rd_idx == pwm_fault_pkg::IDX_FAULT_OVR[5:0]) ? fault_output_override_reg :
        (rd_idx == pwm_fault_pkg::IDX_DLY_CTRL[5:0])  ? delay_control_reg :
        (rd_idx == pwm_fault_pkg::IDX_DLY_LEN[5:0])   ? delay_length_reg :
        (rd_idx == pwm_fault_pkg::IDX_FRAC_SEL[5:0])  ? fraction_phase_select_reg :
        (rd_idx == pwm_fault_pkg::IDX_FRAC_STEP[5:0]) ? {4'h0, fraction_step_value_reg} :
        (rd_idx == pwm_fault_pkg::IDX_HALT_CTRL[5:0]) ? halt_behaviour_control_reg :
        (rd_idx == pwm_fault_pkg::IDX_TRIG_MODE[5:0]) ? {4'h0, trigger_reaction_select_reg} :
        (rd_idx == pwm_fault_pkg::IDX_INT_STATUS[5:0]) ? {5'h00, int_status_reg} :
        (rd_idx == pwm_fault_pkg::IDX_INT_ENABLE[5:0]) ? {5'h00, int_enable_reg} :
        (rd_idx == pwm_fault_pkg::IDX_STATE[5:0])     ? {5'h00, state_reg} :
                                                        8'h00;
    // Bus slave: one write and one read in flight; unmapped reads give zero.
    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
            pending_aw_reg <= 1'b0;
            pending_w_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb0_reg <= 1'b0;
        end else begin
            s_axi_awready <= ~have_aw & ~s_axi_bvalid & ~s_axi_awready;
            s_axi_wready <= ~have_w & ~s_axi_bvalid & ~s_axi_wready;
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                pending_aw_reg <= 1'b0;
                pending_w_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else begin
                pending_aw_reg <= have_aw;
                pending_w_reg <= have_w;
                if (s_axi_bready) s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= ~s_axi_arvalid | s_axi_arready ? 1'b0 :
                             ~s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h0, rd_val};
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    a_override_level: assert property (@(posedge clock) disable iff (rst)
        (state_next != pwm_fault_pkg::ST_RUN) |=>
        ((waveform_output_pin & $past(ovr_en)) ==
         ($past(fault_output_override_reg) & $past(ovr_en))))
        else $error("Override level not applied.");
    a_step_buffered: assert property (@(posedge clock) disable iff (rst)
        !update_condition |=> $stable(step_active_reg))
        else $error("Active step changed without update.");
    a_mode_none_idle: assert property (@(posedge clock) disable iff (rst)
        (state_reg == pwm_fault_pkg::ST_RUN && mode == pwm_fault_pkg::RX_NONE)
        |=> state_reg == pwm_fault_pkg::ST_RUN)
        else $error("No-action mode left run state.");
    a_await_sw_hold: assert property (@(posedge clock) disable iff (rst)
        (state_reg == pwm_fault_pkg::ST_SW && !wr_state) |=>
        state_reg == pwm_fault_pkg::ST_SW)
        else $error("Software wait left without write.");
    a_halt_flags: assert property (@(posedge clock) disable iff (rst)
        halt_evt |=> int_status_reg[1:0] == 2'b11)
        else $error("Halt fault did not set trigger flags.");
    a_break_ignore: assert property (@(posedge clock) disable iff (rst)
        (halted && !halt_flt) |=>
        (int_status_reg[1:0] & ~$past(int_status_reg[1:0])) == 2'b00)
        else $error("Event seen during break.");
    a_locked_write: assert property (@(posedge clock) disable iff (rst)
        (wr_ovr && !unlocked) |=> $stable(fault_output_override_reg))
        else $error("Locked override write took effect.");
    a_delay_off: assert property (@(posedge clock) disable iff (rst)
        (dfunc == pwm_fault_pkg::DLY_OFF && !input_blanking) |=>
        !input_blanking)
        else $error("Blanking started with delay off.");
endmodule

/* rtl/pwm_fault_pkg.sv */
package pwm_fault_pkg;
    // Register indices; the byte address is four times the index, since
    // the printed offsets are not all multiples of four.
    localparam logic [7:0] IDX_FAULT_OVR   = 8'h12;
    localparam logic [7:0] IDX_DLY_CTRL    = 8'h14;
    localparam logic [7:0] IDX_DLY_LEN     = 8'h15;
    localparam logic [7:0] IDX_FRAC_SEL    = 8'h18;
    localparam logic [7:0] IDX_FRAC_STEP   = 8'h19;
    localparam logic [7:0] IDX_HALT_CTRL   = 8'h1e;
    localparam logic [7:0] IDX_TRIG_MODE   = 8'h10;
    localparam logic [7:0] IDX_INT_STATUS  = 8'h30;
    localparam logic [7:0] IDX_INT_ENABLE  = 8'h31;
    localparam logic [7:0] IDX_INT_CLEAR   = 8'h32;
    localparam logic [7:0] IDX_STATE       = 8'h33;
    localparam logic [7:0] IDX_UNLOCK      = 8'h34;
    localparam logic [7:0] UNLOCK_KEY      = 8'hd8;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [3:0] UNLOCK_WINDOW  = 4'h4;
    // Field positions.
    localparam int OVR_EN_LSB    = 4;
    localparam int DLY_DIV_LSB   = 4;
    localparam int DLY_SRC_LSB   = 2;
    localparam int HALT_FAULT_BIT = 2;
    localparam int RUN_BREAK_BIT  = 0;
    // Trigger reaction codes.
    localparam logic [3:0] RX_NONE      = 4'h0;
    localparam logic [3:0] RX_JUMP_OPP  = 4'h1;
    localparam logic [3:0] RX_RUN_OPP   = 4'h2;
    localparam logic [3:0] RX_OPP_FAULT = 4'h3;
    localparam logic [3:0] RX_ALL_KEEP  = 4'h4;
    localparam logic [3:0] RX_ALL_DEAD  = 4'h5;
    localparam logic [3:0] RX_ALL_NEXT  = 4'h6;
    localparam logic [3:0] RX_ALL_SW    = 4'h7;
    localparam logic [3:0] RX_EDGE_NEXT = 4'h8;
    localparam logic [3:0] RX_EDGE_KEEP = 4'h9;
    localparam logic [3:0] RX_LVL_KEEP  = 4'ha;
    // Delay function and source codes.
    localparam logic [1:0] DLY_OFF   = 2'h0;
    localparam logic [1:0] DLY_BLANK = 2'h1;
    localparam logic [1:0] DLY_EVENT = 2'h2;
    localparam logic [1:0] SRC_A_SET = 2'h0;
    localparam logic [1:0] SRC_A_CLR = 2'h1;
    localparam logic [1:0] SRC_B_SET = 2'h2;
    localparam logic [1:0] SRC_END   = 2'h3;
    // Reaction states.
    typedef enum logic [2:0] {
        ST_RUN     = 3'b000,
        ST_OPP     = 3'b001,
        ST_WAIT    = 3'b011,
        ST_FAULTED = 3'b010,
        ST_SW      = 3'b110
    } react_state_t;
endpackage

/* testbench/pwm_switch_model.sv */
`timescale 1ns/10ps
// Power stage seen from the pins: each switch follows its gate one clock
// later, which is a stand-in for the turn-on delay of a real switch.
module pwm_switch_model (
    input  wire logic       clock,
    input  wire logic [3:0] gate,
    output logic      [3:0] state
);
    always_ff @(posedge clock) begin
        state <= gate;
    end
endmodule

/* testbench/pwm_fault_delay_dither_ctrl_test.sv */
`timescale 1ns/10ps
module pwm_fault_delay_dither_ctrl_test;
    logic clock = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic trigger_a = 0, trigger_b = 0, debug_break = 0;
    logic compare_a_set_match = 0, compare_a_clear_match = 0;
    logic compare_b_set_match = 0, compare_b_clear_match = 0;
    logic update_condition = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rd_val;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 0, waveform_in = 4'ha;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, output_event, input_blanking, fraction_adjust_a;
    wire fraction_adjust_b, deadtime_adjust, timer_halted, stop_a, stop_b, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] waveform_output_pin, sw_state;
    int n_mismatch = 0, compares = 0, cyc = 0, n_adj_a = 0, n_adj_b = 0;
    int n_adj_d = 0;
    pwm_fault_delay_dither_ctrl uut (.clock, .rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_a,
        .trigger_b, .debug_break, .compare_a_set_match,
        .compare_a_clear_match, .compare_b_set_match, .compare_b_clear_match,
        .update_condition, .waveform_in, .waveform_output_pin, .output_event,
        .input_blanking, .fraction_adjust_a, .fraction_adjust_b,
        .deadtime_adjust, .timer_halted, .stop_a, .stop_b, .irq);
    pwm_switch_model sw (.clock(clock), .gate(waveform_output_pin),
        .state(sw_state));
    always #20 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        n_adj_a += fraction_adjust_a;
        n_adj_b += fraction_adjust_b;
        n_adj_d += deadtime_adjust;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [7:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Byte addresses are the register index times four.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hf;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        chk("write resp", {6'h0, s_axi_bresp}, 8'h00);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        s_axi_araddr <= a;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        rd_val = s_axi_rdata[7:0];
        chk("read resp", {6'h0, s_axi_rresp}, 8'h00);
        s_axi_rready <= 0;
    endtask
    task automatic cycle_end();
        @(posedge clock) compare_b_clear_match <= 1;
        @(posedge clock) compare_b_clear_match <= 0;
        repeat (3) @(posedge clock);
    endtask
    task automatic test_regs();
        logic [7:0] adr[6] = '{8'h48, 8'h50, 8'h54, 8'h60, 8'h64, 8'h78};
        foreach (adr[i]) begin
            rd(adr[i]);
            chk("reset value", rd_val, 8'h00);
        end
        wr(8'h54, 8'ha5);
        rd(8'h54);
        chk("delay length", rd_val, 8'ha5);
        rd(8'h7c);
        chk("unmapped", rd_val, 8'h00);
        $display("test regs done");
    endtask
    task automatic test_fault();
        chk("pins idle", {4'h0, waveform_output_pin}, {4'h0, waveform_in});
        wr(8'hd0, 8'hd8);
        wr(8'h48, 8'hf5);
        rd(8'h48);
        chk("override reg", rd_val, 8'hf5);
        wr(8'h40, 8'h04);
        wr(8'hc4, 8'h01);
        @(posedge clock) trigger_a <= 1;
        repeat (8) @(posedge clock);
        chk("forced pins", {4'h0, waveform_output_pin}, 8'h05);
        chk("switches", {4'h0, sw_state}, 8'h05);
        chk("stops", {6'h0, stop_b, stop_a}, 8'h03);
        chk("irq set", {7'h0, irq}, 8'h01);
        rd(8'hc0);
        chk("status", rd_val & 8'h01, 8'h01);
        @(posedge clock) trigger_a <= 0;
        repeat (6) @(posedge clock);
        wr(8'hc8, 8'h01);
        repeat (3) @(posedge clock);
        chk("irq clear", {7'h0, irq}, 8'h00);
        wr(8'h40, 8'h07);
        @(posedge clock) trigger_a <= 1;
        @(posedge clock) trigger_a <= 0;
        repeat (8) @(posedge clock);
        chk("sw wait pins", {4'h0, waveform_output_pin}, 8'h05);
        wr(8'hcc, 8'h00);
        repeat (2) @(posedge clock);
        chk("sw release", {4'h0, waveform_output_pin}, 8'h0a);
        $display("test fault done");
    endtask
    task automatic test_dither();
        wr(8'h64, 8'h04);
        repeat (8) cycle_end();
        chk("step unloaded", n_adj_b[7:0], 8'h00);
        @(posedge clock) update_condition <= 1;
        @(posedge clock) update_condition <= 0;
        repeat (8) cycle_end();
        chk("overflows b", n_adj_b[7:0], 8'h02);
        chk("overflows a", n_adj_a[7:0], 8'h00);
        wr(8'h60, 8'h03);
        repeat (4) cycle_end();
        chk("overflows a ab", n_adj_a[7:0], 8'h01);
        chk("deadtime", n_adj_d[7:0], 8'h01);
        $display("test dither done");
    endtask
    task automatic test_break();
        wr(8'h78, 8'h04);
        @(posedge clock) debug_break <= 1;
        repeat (6) @(posedge clock);
        chk("halted", {7'h0, timer_halted}, 8'h01);
        chk("halt pins", {4'h0, waveform_output_pin}, 8'h05);
        rd(8'hc0);
        chk("halt flags", rd_val & 8'h03, 8'h03);
        wr(8'h78, 8'h01);
        repeat (4) @(posedge clock);
        chk("run in break", {7'h0, timer_halted}, 8'h00);
        wr(8'h78, 8'h00);
        wr(8'hc8, 8'h03);
        trigger_b <= 1;
        repeat (6) @(posedge clock);
        rd(8'hc0);
        chk("break ignores", rd_val & 8'h02, 8'h00);
        trigger_b <= 0;
        @(posedge clock) debug_break <= 0;
        repeat (6) @(posedge clock);
        chk("released", {7'h0, timer_halted}, 8'h00);
        $display("test break done");
    endtask
    task automatic test_delay();
        int n;
        wr(8'h54, 8'h03);
        wr(8'h50, 8'h01);
        @(posedge clock) compare_a_set_match <= 1;
        @(posedge clock) compare_a_set_match <= 0;
        n = 0;
        repeat (12) @(posedge clock) n += input_blanking;
        chk("blank cycles", n[7:0], 8'h03);
        wr(8'h54, 8'h02);
        wr(8'h50, 8'h3e);
        cycle_end();
        n = 0;
        repeat (5) @(posedge clock) n += output_event;
        chk("early event", n[7:0], 8'h00);
        repeat (12) @(posedge clock) n += output_event;
        chk("delay event", n[7:0], 8'h01);
        $display("test delay done");
    endtask
    task automatic results();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst <= 0;
        test_regs();
        test_fault();
        test_break();
        test_dither();
        test_delay();
        results();
    end
endmodule
